// [hw/tswd_pkg.sv]
package tswd_pkg;

  localparam int ADDR_W = 8;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SRC1_LO = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SRC1_HI = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_SRC2_LO = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_SRC2_HI = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_UPPER_DVD = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_LO = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_HI = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_CCR = 8'h24;

  // Control word layout
  localparam int CTRL_OPC_LSB = 0;
  localparam int CTRL_IMMSEL_BIT = 6;
  localparam int CTRL_IMM_LSB = 7;
  localparam int CTRL_RSV_LSB = 20;
  localparam int CTRL_GO_BIT = 31;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [30:0] CTRL_STORE_MASK = 31'h0fff_ffff;

  // Opcode field encodings
  localparam logic [5:0] OPC_UDIV = 6'h0e;
  localparam logic [5:0] OPC_SDIV = 6'h0f;
  localparam logic [1:0] OPC_PAIR_PLAIN = 2'b00;
  localparam logic [1:0] OPC_PAIR_CC = 2'b01;
  localparam logic [5:0] OPC_TSUB_FLAGS = 6'h30;
  localparam logic [5:0] OPC_TSUB_TRAP = 6'h31;

  // Status bits
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_TAGOVF = 3;
  localparam int ST_ZERODIV = 4;
  localparam int ST_DESTWR = 5;
  localparam int ST_DIVOVF = 6;

  // Condition code layout: word flags low, doubleword flags high
  localparam int CC_ICC_C = 0;
  localparam int CC_ICC_V = 1;
  localparam int CC_ICC_Z = 2;
  localparam int CC_ICC_N = 3;
  localparam int CC_XCC_C = 4;
  localparam int CC_XCC_V = 5;
  localparam int CC_XCC_Z = 6;
  localparam int CC_XCC_N = 7;
  localparam logic [7:0] CCR_RST = 8'h00;

  // Divide overflow clamps and limits
  localparam logic [63:0] UDIV_CLAMP = 64'h0000_0000_ffff_ffff;
  localparam logic [63:0] SDIV_POS_CLAMP = 64'h0000_0000_7fff_ffff;
  localparam logic [63:0] SDIV_NEG_CLAMP = 64'hffff_ffff_8000_0000;
  localparam logic [63:0] SDIV_NEG_LIMIT = 64'h0000_0000_8000_0000;

  localparam logic [6:0] DIV_STEPS = 7'h40;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic {ST_IDLE, ST_DIV} tswd_state_t;

endpackage

// [hw/tswd_divider.sv]
`timescale 1ns/1ns
// Restoring unsigned 64/32 divider, one quotient bit per clock.
module tswd_divider
  import tswd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [63:0] dividend,
  input wire logic [31:0] divisor,
  output logic done,
  output logic [63:0] quotient
);

  logic [32:0] rem_r;
  logic [31:0] dvs_r;
  logic [6:0] cnt_r;
  logic [32:0] shifted;
  logic fits;

  assign shifted = {rem_r[31:0], quotient[63]};
  assign fits = shifted >= {1'b0, dvs_r};

  // Full 64-bit quotient kept so the caller can see overflow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_r <= '0;
      dvs_r <= '0;
      cnt_r <= '0;
      quotient <= '0;
      done <= 1'b0;
    end else if (start) begin
      rem_r <= '0;
      dvs_r <= divisor;
      cnt_r <= DIV_STEPS;
      quotient <= dividend;
      done <= 1'b0;
    end else if (cnt_r != 7'h0) begin
      rem_r <= fits ? shifted - {1'b0, dvs_r} : shifted;
      quotient <= {quotient[62:0], fits};
      cnt_r <= cnt_r - 7'h1;
      done <= (cnt_r == 7'h1);
    end else begin
      done <= 1'b0;
    end
  end

endmodule

// [hw/tswd_core.sv]
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
// Overview of operation
// - Tag overflow: low two bits of either operand set, or 32-bit signed overflow.
// - Flag-setting tagged subtract writes word overflow flag as the tag overflow.
// - Tagged subtract is first minus second or immediate; other flags as subtract.
// - Flag-setting tagged subtract: register form with bits 12:5 nonzero is illegal.
// - Trapping tagged subtract on tag overflow traps, destination and flags untouched.
// - Trapping tagged subtract without overflow writes difference, clears word overflow.
// - Trapping tagged subtract: register form with bits 12:5 nonzero is illegal.
// - Dividend is upper register above low source word; divisor is low word.
// - Upper dividend register content after a divide is unspecified.
// - Inexact quotients truncate toward zero for both signednesses.
// - Unsigned quotient at or above two to the 32 clamps to all-ones word.
// - Unsigned quotient without overflow is zero-extended to 64 bits.
// - Flag-setting unsigned divide: N/Z from clamped result, word V on overflow.
// - Non-flag-setting divides leave every condition code unchanged.
// - Signed overflow clamps to maximum positive or minimum negative word.
// - Signed quotient without overflow is sign-extended to 64 bits.
// - Flag-setting signed divide: N/Z from the clamped destination value.
// - Any divide: register form with bits 12:5 nonzero is illegal.
// - Divide opcodes are 00 1110 and 00 1111; upper pair 01 writes flags.
module tswd_core
  import tswd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic resultValid,
  output logic destWrite,
  output logic [63:0] destResult,
  output logic [7:0] ccrOut,
  output logic illegalTrap,
  output logic tagOverflowTrap,
  output logic zeroDivisorTrap
);

  tswd_state_t state_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic awHeld_r, wHeld_r, goPulse_r;
  logic [31:0] ctrl_r, src1Lo_r, src1Hi_r, src2Lo_r, src2Hi_r, upperDvd_r;
  logic [6:0] status_r;
  logic divSigned_r, divCc_r, qNeg_r;
  logic doWrite, ccrSwWr, busy;
  logic [31:0] rdMux;
  logic rdHit;

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Write channel: address and data accepted in either order
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign busy = goPulse_r || (state_r == ST_DIV);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !wHeld_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awAddr_r)
          ADDR_CTRL, ADDR_SRC1_LO, ADDR_SRC1_HI, ADDR_SRC2_LO, ADDR_SRC2_HI, ADDR_UPPER_DVD, ADDR_CCR: begin
            s_axi_bresp <= RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Operand registers; the go bit is never stored, it only launches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      src1Lo_r <= '0;
      src1Hi_r <= '0;
      src2Lo_r <= '0;
      src2Hi_r <= '0;
      upperDvd_r <= '0;
      goPulse_r <= 1'b0;
    end else begin
      goPulse_r <= 1'b0;
      if (doWrite) begin
        case (awAddr_r)
          ADDR_CTRL: begin
            ctrl_r <= mergeStrb(ctrl_r, wData_r, wStrb_r) & {1'b0, CTRL_STORE_MASK};
            goPulse_r <= wStrb_r[3] && wData_r[CTRL_GO_BIT] && !busy;
          end
          ADDR_SRC1_LO: src1Lo_r <= mergeStrb(src1Lo_r, wData_r, wStrb_r);
          ADDR_SRC1_HI: src1Hi_r <= mergeStrb(src1Hi_r, wData_r, wStrb_r);
          ADDR_SRC2_LO: src2Lo_r <= mergeStrb(src2Lo_r, wData_r, wStrb_r);
          ADDR_SRC2_HI: src2Hi_r <= mergeStrb(src2Hi_r, wData_r, wStrb_r);
          // Divides leave this register as software wrote it
          ADDR_UPPER_DVD: upperDvd_r <= mergeStrb(upperDvd_r, wData_r, wStrb_r);
          default: begin
          end
        endcase
      end
    end
  end

  assign ccrSwWr = doWrite && (awAddr_r == ADDR_CCR) && wStrb_r[0];

  // Decode and datapath
  logic [5:0] opc;
  logic [12:0] imm13;
  logic [63:0] opA, opB, diff;
  logic isTsubF, isTsubT, isTsub, isDiv, divCcNow, illegalEnc, tagOvf;
  logic [31:0] dvs32;
  logic [63:0] dvd64, dvdMag;
  logic [31:0] dvsMag;
  logic [7:0] subCc;

  assign opc = ctrl_r[CTRL_OPC_LSB +: 6];
  assign imm13 = ctrl_r[CTRL_IMM_LSB +: 13];
  assign opA = {src1Hi_r, src1Lo_r};
  assign opB = ctrl_r[CTRL_IMMSEL_BIT] ? {{51{imm13[12]}}, imm13} : {src2Hi_r, src2Lo_r};
  assign diff = opA - opB;
  assign isTsubF = opc == OPC_TSUB_FLAGS;
  assign isTsubT = opc == OPC_TSUB_TRAP;
  assign isTsub = isTsubF || isTsubT;
  assign isDiv = (opc[3:0] == OPC_UDIV[3:0] || opc[3:0] == OPC_SDIV[3:0])
                 && (opc[5:4] == OPC_PAIR_PLAIN || opc[5:4] == OPC_PAIR_CC);
  assign divCcNow = opc[5:4] == OPC_PAIR_CC;
  // Unknown opcodes also land on the illegal path
  assign illegalEnc = (!ctrl_r[CTRL_IMMSEL_BIT] && ctrl_r[CTRL_RSV_LSB +: 8] != 8'h00)
                      || !(isTsub || isDiv);
  assign tagOvf = (opA[1:0] != 2'b00) || (opB[1:0] != 2'b00)
                  || ((opA[31] != opB[31]) && (diff[31] != opA[31]));
  assign dvs32 = opB[31:0];
  assign dvd64 = {upperDvd_r, src1Lo_r};
  assign dvdMag = (opc[0] && dvd64[63]) ? 64'(-dvd64) : dvd64;
  assign dvsMag = (opc[0] && dvs32[31]) ? 32'(-dvs32) : dvs32;

  always_comb begin
    subCc = '0;
    subCc[CC_ICC_N] = diff[31];
    subCc[CC_ICC_Z] = diff[31:0] == 32'h0;
    subCc[CC_ICC_C] = opA[31:0] < opB[31:0];
    subCc[CC_ICC_V] = isTsubF ? tagOvf : 1'b0;
    subCc[CC_XCC_N] = diff[63];
    subCc[CC_XCC_Z] = diff == 64'h0;
    subCc[CC_XCC_C] = opA < opB;
    subCc[CC_XCC_V] = (opA[63] != opB[63]) && (diff[63] != opA[63]);
  end

  logic divStart, divDone;
  logic [63:0] qMag;

  tswd_divider u_div (
    .clk(clk),
    .rst_n(rst_n),
    .start(divStart),
    .dividend(dvdMag),
    .divisor(dvsMag),
    .done(divDone),
    .quotient(qMag)
  );

  // Magnitude division truncates, so signs applied afterwards round toward zero
  logic divOvf;
  logic [63:0] divRes;
  always_comb begin
    divOvf = 1'b0;
    divRes = '0;
    if (!divSigned_r) begin
      divOvf = qMag[63:32] != 32'h0;
      divRes = divOvf ? UDIV_CLAMP : {32'h0, qMag[31:0]};
    end else if (!qNeg_r) begin
      divOvf = qMag[63:31] != 33'h0;
      divRes = divOvf ? SDIV_POS_CLAMP : {32'h0, qMag[31:0]};
    end else begin
      divOvf = qMag > SDIV_NEG_LIMIT;
      divRes = divOvf ? SDIV_NEG_CLAMP : 64'(-qMag);
    end
  end

  // Completion of an operation, one cycle
  logic finNow, finWrite, finCcWr, finIllegal, finTag, finZdiv;
  logic [63:0] finResult;
  logic [7:0] finCc;

  always_comb begin
    finNow = 1'b0;
    finWrite = 1'b0;
    finCcWr = 1'b0;
    finIllegal = 1'b0;
    finTag = 1'b0;
    finZdiv = 1'b0;
    finResult = '0;
    finCc = '0;
    divStart = 1'b0;
    if (state_r == ST_IDLE && goPulse_r) begin
      finNow = 1'b1;
      if (illegalEnc) begin
        finIllegal = 1'b1;
      end else if (isTsub) begin
        if (isTsubT && tagOvf) begin
          finTag = 1'b1;
        end else begin
          finWrite = 1'b1;
          finResult = diff;
          finCcWr = 1'b1;
          finCc = subCc;
        end
      end else if (dvs32 == 32'h0) begin
        finZdiv = 1'b1;
      end else begin
        finNow = 1'b0;
        divStart = 1'b1;
      end
    end else if (state_r == ST_DIV && divDone) begin
      finNow = 1'b1;
      finWrite = 1'b1;
      finResult = divRes;
      finCcWr = divCc_r;
      finCc[CC_ICC_N] = divRes[31];
      finCc[CC_ICC_Z] = divRes[31:0] == 32'h0;
      finCc[CC_ICC_V] = divOvf;
      finCc[CC_XCC_N] = divRes[63];
      finCc[CC_XCC_Z] = divRes == 64'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      divSigned_r <= 1'b0;
      divCc_r <= 1'b0;
      qNeg_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (divStart) begin
            state_r <= ST_DIV;
            divSigned_r <= opc[0];
            divCc_r <= divCcNow;
            qNeg_r <= opc[0] && (dvd64[63] != dvs32[31]);
          end
        end
        ST_DIV: begin
          if (divDone) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Results and flags; a hardware update beats a software flag write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ccrOut <= CCR_RST;
      destResult <= '0;
      status_r <= '0;
      resultValid <= 1'b0;
      destWrite <= 1'b0;
      illegalTrap <= 1'b0;
      tagOverflowTrap <= 1'b0;
      zeroDivisorTrap <= 1'b0;
    end else begin
      resultValid <= finNow;
      destWrite <= finWrite;
      illegalTrap <= finIllegal;
      tagOverflowTrap <= finTag;
      zeroDivisorTrap <= finZdiv;
      if (finCcWr) begin
        ccrOut <= finCc;
      end else if (ccrSwWr) begin
        ccrOut <= wData_r[7:0];
      end
      if (finWrite) begin
        destResult <= finResult;
      end
      if (finNow) begin
        status_r <= '0;
        status_r[ST_DONE] <= 1'b1;
        status_r[ST_ILLEGAL] <= finIllegal;
        status_r[ST_TAGOVF] <= finTag;
        status_r[ST_ZERODIV] <= finZdiv;
        status_r[ST_DESTWR] <= finWrite;
        status_r[ST_DIVOVF] <= finWrite && state_r == ST_DIV && divOvf;
      end else if (goPulse_r) begin
        status_r <= '0;
      end
    end
  end

  // Read channel
  always_comb begin
    rdHit = 1'b1;
    rdMux = '0;
    case (s_axi_araddr)
      ADDR_CTRL: rdMux = ctrl_r;
      ADDR_SRC1_LO: rdMux = src1Lo_r;
      ADDR_SRC1_HI: rdMux = src1Hi_r;
      ADDR_SRC2_LO: rdMux = src2Lo_r;
      ADDR_SRC2_HI: rdMux = src2Hi_r;
      ADDR_UPPER_DVD: rdMux = upperDvd_r;
      ADDR_STATUS: rdMux = {25'h0, status_r[6:1], busy};
      ADDR_RESULT_LO: rdMux = destResult[31:0];
      ADDR_RESULT_HI: rdMux = destResult[63:32];
      ADDR_CCR: rdMux = {24'h0, ccrOut};
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence tsubIssue;
    state_r == ST_IDLE && goPulse_r && !illegalEnc && isTsub;
  endsequence

  sequence divFinish;
    state_r == ST_DIV && divDone && !ccrSwWr;
  endsequence

  tag_flag_a: assert property (tsubIssue and isTsubF |=> ccrOut[CC_ICC_V] == $past(tagOvf))
    else $error("word overflow flag does not follow tag overflow");
  tsub_diff_a: assert property (tsubIssue and !tagOvf |=> destWrite && destResult == $past(diff))
    else $error("tagged subtract difference wrong");
  enc_illegal_a: assert property (state_r == ST_IDLE && goPulse_r && illegalEnc && !ccrSwWr
    |=> illegalTrap && !destWrite && $stable(ccrOut))
    else $error("illegal encoding not trapped cleanly");
  tag_trap_a: assert property (tsubIssue and isTsubT && tagOvf && !ccrSwWr
    |=> tagOverflowTrap && !destWrite && $stable(ccrOut) && $stable(destResult))
    else $error("trapping subtract altered state");
  trap_nov_a: assert property (tsubIssue and isTsubT && !tagOvf |=> !ccrOut[CC_ICC_V] && !tagOverflowTrap)
    else $error("trapping subtract did not clear word overflow");
  div_time_a: assert property (divStart |-> ##66 (resultValid && destWrite))
    else $error("divide result not delivered on time");
  udiv_ext_a: assert property (divFinish and !divSigned_r |=> destResult[63:32] == 32'h0)
    else $error("unsigned divide result not zero-extended");
  sdiv_ext_a: assert property (divFinish and divSigned_r |=> destResult[63:32] == {32{destResult[31]}})
    else $error("signed divide result not sign-extended");
  div_nocc_a: assert property (divFinish and !divCc_r |=> $stable(ccrOut))
    else $error("plain divide changed condition codes");
  divcc_flags_a: assert property (divFinish and divCc_r |=> ccrOut[CC_ICC_N] == destResult[31]
    && ccrOut[CC_XCC_Z] == (destResult == 64'h0) && ccrOut[CC_ICC_C] == 1'b0 && ccrOut[CC_XCC_V] == 1'b0
    && ccrOut[CC_ICC_V] == status_r[ST_DIVOVF])
    else $error("flag-setting divide flags wrong");
  zero_div_a: assert property (state_r == ST_IDLE && goPulse_r && !illegalEnc && isDiv && dvs32 == 32'h0
    && !ccrSwWr |=> zeroDivisorTrap && !destWrite && $stable(ccrOut))
    else $error("zero divisor not trapped cleanly");

endmodule

// [testbench/tswd_host.sv]
`timescale 1ns/1ns
// Register-bus master standing in for the issuing pipeline
module tswd_host
  import tswd_pkg::*;
(
  input wire logic clk,
  output logic [ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int hangs = 0;

  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
  end

  // Released payloads are inverted so a stale value can never pass for a live one
  task automatic write(input logic [ADDR_W-1:0] addr, input logic [31:0] data, output logic [1:0] resp);
    logic aw;
    logic w;
    logic b;
    int n;
    @(posedge clk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    aw = 1'h1;
    w = 1'h1;
    b = 1'h0;
    n = 0;
    resp = 2'h3;
    while (!b && n < 200) begin
      @(posedge clk);
      n++;
      if (aw && s_axi_awready) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
        s_axi_awaddr <= ~addr;
      end
      if (w && s_axi_wready) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
        s_axi_wdata <= ~data;
      end
      if (s_axi_bvalid) begin
        b = 1'h1;
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
      end
    end
    if (!b) hangs++;
  endtask

  task automatic read(input logic [ADDR_W-1:0] addr, output logic [31:0] data, output logic [1:0] resp);
    logic ar;
    logic r;
    int n;
    @(posedge clk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    ar = 1'h1;
    r = 1'h0;
    n = 0;
    data = 32'h0;
    resp = 2'h3;
    while (!r && n < 200) begin
      @(posedge clk);
      n++;
      if (ar && s_axi_arready) begin
        ar = 1'h0;
        s_axi_arvalid <= 1'h0;
        s_axi_araddr <= ~addr;
      end
      if (s_axi_rvalid) begin
        r = 1'h1;
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
      end
    end
    if (!r) hangs++;
  endtask
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ns
module tb_top
  import tswd_pkg::*;
;
  localparam logic [5:0] UDIV_CC = {OPC_PAIR_CC, OPC_UDIV[3:0]};
  localparam logic [5:0] SDIV_CC = {OPC_PAIR_CC, OPC_SDIV[3:0]};
  logic clk, rst_n;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdVal;
  logic [3:0] s_axi_wstrb, ev;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic resultValid, destWrite, illegalTrap, tagOverflowTrap, zeroDivisorTrap;
  logic [63:0] destResult;
  logic [7:0] ccrOut;
  int mismatches, totalChecks;

  tswd_core dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .resultValid(resultValid), .destWrite(destWrite), .destResult(destResult), .ccrOut(ccrOut),
    .illegalTrap(illegalTrap), .tagOverflowTrap(tagOverflowTrap), .zeroDivisorTrap(zeroDivisorTrap));

  tswd_host host (.clk(clk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Pulses last one cycle, so latch them for the later register-side check
  always @(posedge clk) begin
    if (resultValid === 1'h1) ev <= {tagOverflowTrap, zeroDivisorTrap, illegalTrap, destWrite};
  end

  task automatic test_done;
    if (mismatches == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    totalChecks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic guard;
    if (host.hangs != 0) begin
      mismatches++;
      $display("Error bus answer expected 1 seen 0");
      test_done;
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    host.write(a, d, resp);
    guard;
    chk("bresp", 64'(er), 64'(resp));
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] er);
    host.read(a, rdVal, resp);
    guard;
    chk("rresp", 64'(er), 64'(resp));
  endtask

  task automatic run(input logic [5:0] opc, input logic immSel, input logic [12:0] imm, input logic [7:0] ib,
                     input logic [63:0] a, input logic [63:0] b, input logic [31:0] up);
    int n;
    ev = 4'h0;
    wr(ADDR_SRC1_LO, a[31:0], RESP_OKAY);
    wr(ADDR_SRC1_HI, a[63:32], RESP_OKAY);
    wr(ADDR_SRC2_LO, b[31:0], RESP_OKAY);
    wr(ADDR_SRC2_HI, b[63:32], RESP_OKAY);
    wr(ADDR_UPPER_DVD, up, RESP_OKAY);
    wr(ADDR_CTRL, {1'h1, 3'h0, ib, imm, immSel, opc}, RESP_OKAY);
    n = 0;
    rdVal = 32'h0;
    while (rdVal[ST_DONE] !== 1'h1 && n < 60) begin
      rd(ADDR_STATUS, RESP_OKAY);
      n++;
    end
    if (rdVal[ST_DONE] !== 1'h1) begin
      mismatches++;
      $display("Error done flag expected 1 seen 0");
      test_done;
    end
  endtask

  // Event order: tag overflow, zero divisor, illegal, destination written
  task automatic outcome(input logic [3:0] e, input logic [63:0] res, input logic [7:0] cc);
    chk("events", 64'(e), 64'(ev));
    chk("status", 64'({2'h0, e[0], e[2], e[3], e[1], 2'h2}), 64'(rdVal & 32'h3f));
    rd(ADDR_RESULT_LO, RESP_OKAY);
    chk("result lo", 64'(res[31:0]), 64'(rdVal));
    rd(ADDR_RESULT_HI, RESP_OKAY);
    chk("result hi", 64'(res[63:32]), 64'(rdVal));
    rd(ADDR_CCR, RESP_OKAY);
    chk("ccr reg", 64'(cc), 64'(rdVal));
    chk("dest port", res, destResult);
    chk("ccr port", 64'(cc), 64'(ccrOut));
  endtask

  initial begin
    mismatches = 0;
    totalChecks = 0;
    ev = 4'h0;
    rst_n = 1'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    rd(ADDR_CCR, RESP_OKAY);
    chk("ccr reset", 64'(CCR_RST), 64'(rdVal));
    rd(ADDR_CTRL, RESP_OKAY);
    chk("ctrl reset", 64'(CTRL_RST), 64'(rdVal));
    run(OPC_TSUB_FLAGS, 1'h0, 13'h0, 8'h0, 64'h8, 64'h4, 32'h0);
    outcome(4'h1, 64'h4, 8'h00);
    run(OPC_TSUB_FLAGS, 1'h0, 13'h0, 8'h0, 64'h8, 64'h5, 32'h0);
    outcome(4'h1, 64'h3, 8'h02);
    run(OPC_TSUB_FLAGS, 1'h0, 13'h0, 8'h0, 64'h8000_0000, 64'h4, 32'h0);
    outcome(4'h1, 64'h7fff_fffc, 8'h02);
    run(OPC_TSUB_FLAGS, 1'h1, 13'h1ffc, 8'h0, 64'h8, 64'h3, 32'h0);
    outcome(4'h1, 64'hc, 8'h11);
    wr(ADDR_CCR, 32'h5a, RESP_OKAY);
    run(OPC_TSUB_FLAGS, 1'h0, 13'h0, 8'h01, 64'h8, 64'h4, 32'h0);
    outcome(4'h2, 64'hc, 8'h5a);
    run(OPC_TSUB_TRAP, 1'h0, 13'h0, 8'h80, 64'h8, 64'h4, 32'h0);
    outcome(4'h2, 64'hc, 8'h5a);
    run(OPC_TSUB_TRAP, 1'h0, 13'h0, 8'h0, 64'h8, 64'h5, 32'h0);
    outcome(4'h8, 64'hc, 8'h5a);
    run(OPC_TSUB_TRAP, 1'h0, 13'h0, 8'h0, 64'hc, 64'h4, 32'h0);
    outcome(4'h1, 64'h8, 8'h00);
    wr(ADDR_CCR, 32'h5a, RESP_OKAY);
    run(OPC_UDIV, 1'h0, 13'h0, 8'h0, 64'h5555_5555_0000_0000, 64'hffff_ffff_0000_0002, 32'h1);
    outcome(4'h1, 64'h8000_0000, 8'h5a);
    run(OPC_SDIV, 1'h0, 13'h0, 8'h0, 64'hffff_fff9, 64'h4, 32'hffff_ffff);
    outcome(4'h1, 64'hffff_ffff_ffff_ffff, 8'h5a);
    run(UDIV_CC, 1'h0, 13'h0, 8'h0, 64'h0, 64'h1, 32'h1);
    outcome(4'h1, 64'hffff_ffff, 8'h0a);
    run(UDIV_CC, 1'h0, 13'h0, 8'h0, 64'h3, 64'h4, 32'h0);
    outcome(4'h1, 64'h0, 8'h44);
    run(SDIV_CC, 1'h0, 13'h0, 8'h0, 64'h8000_0000, 64'h1, 32'h0);
    outcome(4'h1, 64'h7fff_ffff, 8'h02);
    run(SDIV_CC, 1'h1, 13'h1fff, 8'h0, 64'h8000_0001, 64'h3, 32'h0);
    outcome(4'h1, 64'hffff_ffff_8000_0000, 8'h8a);
    run(OPC_UDIV, 1'h0, 13'h0, 8'h80, 64'h4, 64'h2, 32'h0);
    outcome(4'h2, 64'hffff_ffff_8000_0000, 8'h8a);
    run(UDIV_CC, 1'h0, 13'h0, 8'h0, 64'h5, 64'hffff_ffff_0000_0000, 32'h0);
    outcome(4'h4, 64'hffff_ffff_8000_0000, 8'h8a);
    wr(8'h40, 32'h1, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h0, RESP_SLVERR);
    rd(8'h40, RESP_SLVERR);
    chk("unmapped read", 64'h0, 64'(rdVal));
    test_done;
  end
endmodule
